// ==== src/dsc_pkg.sv ====
// constants shared by the disc sector read/write sequencer and its helpers
// assumes a single 25 MHz design clock; disc clocks arrive as plain pins
// Summary of operation
// - power-up reset clears the latch that records a sector-address match
// - power-up reset clears the sector and subsector address registers
// - write clock and sector clock both high give sector sync, setting write-sync latch
// - write-sector-go start waits 120 ns before shift-register clock rises
// - release of write-sector-go sets the write-sector latch
// - write latch sets at sync rise on match, write permitted and write-sector latch
// - shift-register clock rises on delayed go strobe, falls on go release
// - each write clock pulse while writing gives a write shift and register clock pulse
// - load strobe follows write-sector-go, again when load enable rises at count 15
// - buffer empty at count 15 gives write timing error, late flag on next shift
// - read-sector-go sets read-start latch, presets counter to 15, clocks it after delay
// - read latch sets at sync rise on match; next write clock raises disc read command
// - first read clock after read latch sets read-sync; then each gives a read shift
// - reading: load-count strobe after 15 bits, buffer-load strobe at 16 bits
// - each read shift pulse also gives a shift-register clock pulse
// - buffer full at a read buffer-load strobe sets the data-late flag
// - write-sector latch clears when write flag drops or write latch sets
// - write and read latches clear on init, operation flag drop or end strobe
// - read-sync latch clears when the read operation flag drops
// - write-sync latch also clears while track origin is asserted
// - write start clears both 4-bit counters; write-sector latch enables the upper one
// - bit and word counter counts up on write and read shifts and flags the final word
package dsc_pkg;
  // ==========================================================
  // register map, byte addresses on the plain register port
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_ADDR = 4'h4;
  localparam logic [3:0] OFF_STAT = 4'h8;
  localparam logic [3:0] OFF_CNT = 4'hc;
  // control fields
  localparam int CTRL_WR = 0;
  localparam int CTRL_RD = 1;
  // address fields
  localparam int SEC_LSB = 0;
  localparam int SEC_W = 5;
  localparam int SUB_LSB = 8;
  localparam int SUB_W = 4;
  // status fields; writing one to the late bit clears it
  localparam int ST_LATE = 7;
  // count register fields
  localparam int CNT_WORD_LSB = 4;
  // ==========================================================
  // timing
  localparam int CLK_NS = 40;
  localparam int GO_DELAY_NS = 120;
  localparam int GO_DELAY_CYC = (GO_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int RC_DELAY_NS = 200;
  localparam int RC_DELAY_CYC = (RC_DELAY_NS + CLK_NS - 1) / CLK_NS;
  // ==========================================================
  // counter and synchroniser layout
  localparam logic [3:0] BIT_LAST = 4'hf;
  localparam logic [3:0] BIT_PRESET = 4'hf;
  localparam int SY_WCLK = 0;
  localparam int SY_SCLK = 1;
  localparam int SY_RCLK = 2;
  localparam int SY_TORG = 3;
  localparam int SY_PERM = 4;
  localparam int SY_N = 5;
endpackage : dsc_pkg

// ==== src/dsc_sync.sv ====
// two-stage synchroniser for disc pins
// assumes inputs are asynchronous to clock; stage one feeds only stage two
`timescale 1ns/1ns
module dsc_sync #(
  parameter int WIDTH = 5
) (
  input wire logic clock, // design clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [WIDTH-1:0] pin_in, // raw pins
  output logic [WIDTH-1:0] sync_out // synchronised levels
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } dsc_sync_st_t;

  dsc_sync_st_t s_q;
  dsc_sync_st_t s_d;

  if (WIDTH < 1)
  begin : bad_width_g
    $error("dsc_sync: WIDTH must be at least one");
  end

  // ==========================================================
  // stage one is read by stage two only
  always_comb
  begin
    s_d.meta = pin_in;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign sync_out = s_q.stable;
endmodule : dsc_sync

// ==== src/dsc_bit_counter.sv ====
// cascaded bit and word counter, two 4-bit stages
// assumes clear, preset and step are same-clock single-cycle terms
`timescale 1ns/1ns
module dsc_bit_counter #(
  parameter int WIDTH = 4
) (
  input wire logic clock, // design clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic clear, // clear both stages
  input wire logic preset, // load bit stage with preset
  input wire logic step, // count one bit
  input wire logic upper_en, // lets the word stage count
  output logic [WIDTH-1:0] bit_count, // bits in current word
  output logic [WIDTH-1:0] word_count // words in subsector
);
  typedef struct packed {
    logic [WIDTH-1:0] bits;
    logic [WIDTH-1:0] words;
  } dsc_cnt_st_t;

  dsc_cnt_st_t s_q;
  dsc_cnt_st_t s_d;

  if (WIDTH != 4)
  begin : bad_width_g
    $error("dsc_bit_counter: stages are 4 bits");
  end

  // ==========================================================
  // clear beats preset beats step; word stage advances on bit wrap
  always_comb
  begin
    s_d = s_q;
    if (clear)
      s_d = '0;
    else if (preset)
      s_d.bits = dsc_pkg::BIT_PRESET;
    else if (step)
    begin
      s_d.bits = s_q.bits + 4'h1;
      if (upper_en && s_q.bits == dsc_pkg::BIT_LAST)
        s_d.words = s_q.words + 4'h1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign bit_count = s_q.bits;
  assign word_count = s_q.words;
endmodule : dsc_bit_counter

// ==== src/dsc_sector_ctl.sv ====
// sector read/write sequencer: sync, latches, shift strobes, data-late check
// assumes go, init, end and buffer flags come from logic on the same clock;
// disc clocks, track origin and write-permit are pins and are synchronised
`timescale 1ns/1ns
module dsc_sector_ctl (
  input wire logic clock, // 25 MHz design clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [3:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after reg_rd
  input wire logic write_clock_pin, // disc write clock
  input wire logic sector_clock_pin, // disc sector clock
  input wire logic read_clock_pin, // disc read clock
  input wire logic track_origin_pin, // disc track origin
  input wire logic write_permitted, // lockout switch permits write
  input wire logic [4:0] disc_sector, // sector now under the heads
  input wire logic write_sector_go, // sector-start one-shot, write
  input wire logic read_sector_go, // sector-start one-shot, read
  input wire logic init_strobe, // start of an operation
  input wire logic transfer_end_strobe, // end of transfer
  input wire logic buffer_empty, // memory buffer empty
  input wire logic buffer_full, // memory buffer full
  output logic sector_match_latch, // last sync saw a match
  output logic sector_sync_pulse, // write and sector clocks both high
  output logic write_sync_latch, // write sync latch
  output logic delayed_write_go_strobe, // go delayed by 120 ns
  output logic shift_register_clock, // shift register clock
  output logic write_sector_latch, // write sector latch
  output logic write_latch, // write latch
  output logic disc_write_gate, // write gate to disc
  output logic read_start_latch, // read start latch
  output logic read_latch, // read latch
  output logic disc_read_cmd, // read command to disc
  output logic read_sync_latch, // read sync latch
  output logic write_shift_pulse, // one per write clock
  output logic read_shift_pulse, // one per read clock
  output logic shift_load_strobe, // shift register load
  output logic write_load_enable, // 15 bits counted, writing
  output logic write_timing_error_strobe, // buffer empty at count 15
  output logic read_timing_error_strobe, // buffer full at load
  output logic data_late_error, // sticky data-late flag
  output logic buffer_load_count_strobe, // 15 bits read
  output logic buffer_load_strobe, // 16 bits read
  output logic final_word_flag // last word of subsector
);
  localparam int DW = 8;
  localparam logic [DW-1:0] GO_LAST = DW'(dsc_pkg::GO_DELAY_CYC - 1);
  localparam logic [DW-1:0] RC_LAST = DW'(dsc_pkg::RC_DELAY_CYC - 1);

  if (dsc_pkg::GO_DELAY_CYC < 1 || dsc_pkg::GO_DELAY_CYC > 255 ||
      dsc_pkg::RC_DELAY_CYC < 1 || dsc_pkg::RC_DELAY_CYC > 255)
  begin : bad_delay_g
    $error("dsc_sector_ctl: delay counts out of range");
  end

  typedef struct packed {
    logic wclk_prev;
    logic rclk_prev;
    logic sync_prev;
    logic write_sector_go_prev;
    logic read_sector_go_prev;
    logic [DW-1:0] go_cnt;
    logic dgo;
    logic [DW-1:0] rc_cnt;
    logic rc_busy;
    logic rc_fire;
    logic upper_en;
    logic ctrl_wr;
    logic ctrl_rd;
    logic [4:0] sector;
    logic [3:0] subsector;
    logic match;
    logic sync;
    logic wsync;
    logic wsect;
    logic wl;
    logic wgate;
    logic rstart;
    logic rl;
    logic rcmd;
    logic rsync;
    logic wshift;
    logic rshift;
    logic src;
    logic load;
    logic wload;
    logic wr_terr;
    logic rd_terr;
    logic late;
    logic bl_count;
    logic bl_load;
    logic final_word;
    logic [31:0] rdata;
  } dsc_ctl_st_t;

  dsc_ctl_st_t s_q;
  dsc_ctl_st_t s_d;
  logic [dsc_pkg::SY_N-1:0] sy;
  logic [3:0] bit_count;
  logic [3:0] word_count;
  logic sync_lvl;
  logic sync_rise;
  logic wclk_rise;
  logic rclk_rise;
  logic write_sector_go_rise;
  logic write_sector_go_fall;
  logic read_sector_go_rise;
  logic wshift_now;
  logic rshift_now;
  logic cnt_step;
  logic sector_match;
  logic op_stop;

  // ==========================================================
  // pin synchronisers and bit/word counter
  dsc_sync #(
    .WIDTH(dsc_pkg::SY_N)
  ) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pin_in({write_permitted, track_origin_pin, read_clock_pin, sector_clock_pin, write_clock_pin}),
    .sync_out(sy)
  );

  dsc_bit_counter #(
    .WIDTH(4)
  ) u_cnt (
    .clock(clock),
    .rst_n(rst_n),
    .clear(write_sector_go_rise),
    .preset(read_sector_go_rise),
    .step(cnt_step),
    .upper_en(s_q.upper_en),
    .bit_count(bit_count),
    .word_count(word_count)
  );

  // ==========================================================
  // edge terms; only stage-two synchroniser outputs are looked at
  assign sync_lvl = sy[dsc_pkg::SY_WCLK] & sy[dsc_pkg::SY_SCLK];
  assign sync_rise = sync_lvl & ~s_q.sync_prev;
  assign wclk_rise = sy[dsc_pkg::SY_WCLK] & ~s_q.wclk_prev;
  assign rclk_rise = sy[dsc_pkg::SY_RCLK] & ~s_q.rclk_prev;
  assign write_sector_go_rise = write_sector_go & ~s_q.write_sector_go_prev;
  assign write_sector_go_fall = ~write_sector_go & s_q.write_sector_go_prev;
  assign read_sector_go_rise = read_sector_go & ~s_q.read_sector_go_prev;
  assign wshift_now = wclk_rise & s_q.wl;
  assign rshift_now = rclk_rise & s_q.rsync;
  assign cnt_step = s_q.rc_fire | wshift_now | rshift_now;
  assign sector_match = (s_q.sector == disc_sector);
  assign op_stop = init_strobe | transfer_end_strobe;

  // ==========================================================
  // next state: register port first, then the sequencing latches
  always_comb
  begin
    s_d = s_q;
    s_d.wclk_prev = sy[dsc_pkg::SY_WCLK];
    s_d.rclk_prev = sy[dsc_pkg::SY_RCLK];
    s_d.sync_prev = sync_lvl;
    s_d.write_sector_go_prev = write_sector_go;
    s_d.read_sector_go_prev = read_sector_go;
    s_d.rdata = '0;
    s_d.rc_fire = 1'b0;

    // register writes
    if (reg_wr)
    begin
      case (reg_addr)
        dsc_pkg::OFF_CTRL:
        begin
          s_d.ctrl_wr = reg_wdata[dsc_pkg::CTRL_WR];
          s_d.ctrl_rd = reg_wdata[dsc_pkg::CTRL_RD];
        end
        dsc_pkg::OFF_ADDR:
        begin
          s_d.sector = reg_wdata[dsc_pkg::SEC_LSB +: dsc_pkg::SEC_W];
          s_d.subsector = reg_wdata[dsc_pkg::SUB_LSB +: dsc_pkg::SUB_W];
        end
        dsc_pkg::OFF_STAT:
        begin
          if (reg_wdata[dsc_pkg::ST_LATE])
            s_d.late = 1'b0;
        end
        default:
        begin
          s_d.late = s_q.late;
        end
      endcase
    end

    // register reads, unmapped addresses read zero
    if (reg_rd)
    begin
      case (reg_addr)
        dsc_pkg::OFF_CTRL: s_d.rdata = 32'({s_q.ctrl_rd, s_q.ctrl_wr});
        dsc_pkg::OFF_ADDR: s_d.rdata = 32'({s_q.subsector, 3'h0, s_q.sector});
        dsc_pkg::OFF_STAT: s_d.rdata = 32'({s_q.late, s_q.rsync, s_q.rl, s_q.rstart,
                                             s_q.wl, s_q.wsect, s_q.wsync, s_q.match});
        dsc_pkg::OFF_CNT: s_d.rdata = 32'({word_count, bit_count});
        default: s_d.rdata = '0;
      endcase
    end

    // sector sync and the match record taken at each sync rise
    s_d.sync = sync_lvl;
    if (sync_rise)
      s_d.match = sector_match;

    // write sync: cleared by write clock after sync, or by track origin; set wins
    if (sy[dsc_pkg::SY_TORG] || (wclk_rise && !sync_lvl))
      s_d.wsync = 1'b0;
    if (sync_lvl)
      s_d.wsync = 1'b1;

    // go delay: counts while go is high, strobe stands until go drops
    if (!write_sector_go)
    begin
      s_d.go_cnt = '0;
      s_d.dgo = 1'b0;
    end
    else if (!s_q.dgo)
    begin
      if (s_q.go_cnt == GO_LAST)
        s_d.dgo = 1'b1;
      else
        s_d.go_cnt = s_q.go_cnt + 8'h01;
    end

    // read start and the single counter stroke after the rc delay
    if (read_sector_go_rise)
    begin
      s_d.rc_busy = 1'b1;
      s_d.rc_cnt = '0;
    end
    else if (s_q.rc_busy)
    begin
      if (s_q.rc_cnt == RC_LAST)
      begin
        s_d.rc_busy = 1'b0;
        s_d.rc_fire = 1'b1;
      end
      else
        s_d.rc_cnt = s_q.rc_cnt + 8'h01;
    end

    // write sector latch; set on go release wins over its clears
    if (!s_q.ctrl_wr || s_q.wl)
      s_d.wsect = 1'b0;
    if (write_sector_go_fall)
      s_d.wsect = 1'b1;

    // upper counter enable
    if (write_sector_go_rise || read_sector_go_rise)
      s_d.upper_en = 1'b0;
    if (s_q.wsect || s_q.rsync)
      s_d.upper_en = 1'b1;

    // write and read latches
    if (op_stop || !s_q.ctrl_wr)
      s_d.wl = 1'b0;
    if (op_stop || !s_q.ctrl_rd)
      s_d.rl = 1'b0;
    if (op_stop || !s_q.ctrl_rd)
      s_d.rstart = 1'b0;
    if (read_sector_go_rise)
      s_d.rstart = 1'b1;
    if (sync_rise && sector_match && sy[dsc_pkg::SY_PERM] && s_q.wsect)
      s_d.wl = 1'b1;
    if (sync_rise && sector_match && s_q.rstart && s_q.ctrl_rd)
      s_d.rl = 1'b1;

    // disc write gate and read command follow their latch on a write clock
    if (!s_q.wl)
      s_d.wgate = 1'b0;
    else if (wclk_rise)
      s_d.wgate = 1'b1;
    if (!s_q.rl)
      s_d.rcmd = 1'b0;
    else if (wclk_rise)
      s_d.rcmd = 1'b1;

    // read sync: first read clock after the read latch
    if (!s_q.ctrl_rd)
      s_d.rsync = 1'b0;
    if (rclk_rise && s_q.rl)
      s_d.rsync = 1'b1;

    // shift pulses and the shift register clock
    s_d.wshift = wshift_now;
    s_d.rshift = rshift_now;
    s_d.src = (s_d.dgo & write_sector_go) | wshift_now | rshift_now;

    // write load and the empty-buffer check at count 15
    s_d.wload = s_q.ctrl_wr & s_q.wl & (bit_count == dsc_pkg::BIT_LAST);
    s_d.load = write_sector_go | s_d.wload;
    s_d.wr_terr = s_d.wload & buffer_empty;

    // read side buffer strobes and the full-buffer check
    s_d.bl_count = s_q.rl & (bit_count == dsc_pkg::BIT_LAST);
    s_d.bl_load = rshift_now & (bit_count == dsc_pkg::BIT_LAST);
    s_d.rd_terr = s_d.bl_load & buffer_full;

    // data-late flag: hardware set wins over a software clear
    if ((wshift_now && s_q.wr_terr) || s_q.rd_terr)
      s_d.late = 1'b1;

    s_d.final_word = (word_count == dsc_pkg::BIT_LAST);
  end

  // ==========================================================
  // the one state register; power-up reset clears addresses and match
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // ==========================================================
  // outputs, straight from the state register
  assign reg_rdata = s_q.rdata;
  assign sector_match_latch = s_q.match;
  assign sector_sync_pulse = s_q.sync;
  assign write_sync_latch = s_q.wsync;
  assign delayed_write_go_strobe = s_q.dgo;
  assign shift_register_clock = s_q.src;
  assign write_sector_latch = s_q.wsect;
  assign write_latch = s_q.wl;
  assign disc_write_gate = s_q.wgate;
  assign read_start_latch = s_q.rstart;
  assign read_latch = s_q.rl;
  assign disc_read_cmd = s_q.rcmd;
  assign read_sync_latch = s_q.rsync;
  assign write_shift_pulse = s_q.wshift;
  assign read_shift_pulse = s_q.rshift;
  assign shift_load_strobe = s_q.load;
  assign write_load_enable = s_q.wload;
  assign write_timing_error_strobe = s_q.wr_terr;
  assign read_timing_error_strobe = s_q.rd_terr;
  assign data_late_error = s_q.late;
  assign buffer_load_count_strobe = s_q.bl_count;
  assign buffer_load_strobe = s_q.bl_load;
  assign final_word_flag = s_q.final_word;

  // ==========================================================
  // checks
  match_reset_a: assert property (@(posedge clock) !rst_n |=> !s_q.match)
    else $error("match latch not cleared by reset");
  addr_reset_a: assert property (@(posedge clock) !rst_n |=> s_q.sector == 5'h00 && s_q.subsector == 4'h0)
    else $error("address registers not cleared by reset");
  wsync_set_a: assert property (@(posedge clock) disable iff (!rst_n) sync_lvl |=> s_q.wsync && s_q.sync)
    else $error("sector sync did not set write sync");
  go_hold_a: assert property (@(posedge clock) disable iff (!rst_n) $rose(write_sector_go) |=> !s_q.dgo ##1 !s_q.dgo)
    else $error("delayed go strobe came early");
  go_delay_a: assert property (@(posedge clock) disable iff (!rst_n)
    ($rose(write_sector_go) ##1 write_sector_go [*2]) |=> s_q.dgo && s_q.src)
    else $error("delayed go strobe missing after 120 ns");
  wsect_set_a: assert property (@(posedge clock) disable iff (!rst_n) $fell(write_sector_go) |=> ##1 s_q.wsect)
    else $error("write sector latch not set on go release");
  wlatch_cause_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(s_q.wl) |-> $past(s_q.wsect) && $past(sync_rise) && $past(sy[dsc_pkg::SY_PERM]))
    else $error("write latch set without its conditions");
  late_write_a: assert property (@(posedge clock) disable iff (!rst_n) (wshift_now && s_q.wr_terr) |=> s_q.late)
    else $error("write timing error did not set late flag");
  late_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    s_q.rd_terr |-> s_q.bl_load ##1 s_q.late)
    else $error("read timing error without load or late flag");
  rsync_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!s_q.ctrl_rd ##1 !s_q.ctrl_rd) |=> !s_q.rsync)
    else $error("read sync latch held with read flag low");
endmodule : dsc_sector_ctl

// ==== tb/dsc_disc_model.sv ====
// disc unit stand-in: free write clock, sector marks, gated read clock
// assumes nothing of the design clock; every pin moves on its own timebase
`timescale 1ns/1ns
module dsc_disc_model (
  input wire logic disc_read_cmd, // read command from the sequencer
  output logic write_clock_pin = 1'b0, // 320 ns write clock
  output logic sector_clock_pin = 1'b0, // high with one write clock in twenty
  output logic read_clock_pin = 1'b0, // runs only while reading
  output logic track_origin_pin = 1'b0, // short mark in sector zero
  output logic [4:0] disc_sector = 5'h00 // sector under the heads
);
  int wcnt = 0;
  // ==========
  // write clock and sector timing; the sector number moves mid-sector so it is steady at sync
  always
  begin
    #160;
    write_clock_pin = ~write_clock_pin;
    if (write_clock_pin)
      wcnt = (wcnt + 1) % 20;
    sector_clock_pin = write_clock_pin && (wcnt == 0);
    if (write_clock_pin && wcnt == 10)
      disc_sector = disc_sector + 5'h01;
    track_origin_pin = (disc_sector == 5'h00) && (wcnt == 5);
  end
  // read clock stands still at low outside a read, offset from the write clock
  initial
  begin
    #80;
    forever
    begin
      #160;
      read_clock_pin = disc_read_cmd ? ~read_clock_pin : 1'b0;
    end
  end
endmodule : dsc_disc_model

// ==== tb/test_disc_sector_rw_control.sv ====
// self-checking bench: register port, one write pass, one read pass
// assumes the disc model drives the pins; counters below predict shift totals
`timescale 1ns/1ns
module test_disc_sector_rw_control;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd;
  logic reg_wr = 1'b0, reg_rd = 1'b0, permit = 1'b1, wgo = 1'b0, rgo = 1'b0;
  logic init = 1'b0, tend = 1'b0, bempty = 1'b0, bfull = 1'b0, srk_q = 1'b0;
  logic wclk, sclk, rclk, torg, rcmd, match, dgo, srk, wsl, wl, gate, rsl, rl, rsync, wsp, rsp, sld, wle, late, bld;
  logic ssp, wsy, wte, rte, blc, fw;
  logic [4:0] dsec, sec;
  int n_errors = 0, n_compared = 0, seed = 84, cyc = 0, n_wsp = 0, n_rsp = 0, n_srk = 0, b1, b2, i;

  dsc_disc_model i_disc (.disc_read_cmd(rcmd), .write_clock_pin(wclk), .sector_clock_pin(sclk),
    .read_clock_pin(rclk), .track_origin_pin(torg), .disc_sector(dsec));
  dsc_sector_ctl i_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .write_clock_pin(wclk), .sector_clock_pin(sclk),
    .read_clock_pin(rclk), .track_origin_pin(torg), .write_permitted(permit), .disc_sector(dsec),
    .write_sector_go(wgo), .read_sector_go(rgo), .init_strobe(init), .transfer_end_strobe(tend),
    .buffer_empty(bempty), .buffer_full(bfull), .sector_match_latch(match), .sector_sync_pulse(ssp),
    .write_sync_latch(wsy), .delayed_write_go_strobe(dgo), .shift_register_clock(srk), .write_sector_latch(wsl),
    .write_latch(wl), .disc_write_gate(gate), .read_start_latch(rsl), .read_latch(rl), .disc_read_cmd(rcmd),
    .read_sync_latch(rsync), .write_shift_pulse(wsp), .read_shift_pulse(rsp), .shift_load_strobe(sld),
    .write_load_enable(wle), .write_timing_error_strobe(wte), .read_timing_error_strobe(rte),
    .data_late_error(late), .buffer_load_count_strobe(blc), .buffer_load_strobe(bld), .final_word_flag(fw));

  // ==========
  // clock, timeout and the counting model of shift strokes
  always #20 clock = ~clock;
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    srk_q <= srk;
    if (wsp === 1'b1) n_wsp <= n_wsp + 1;
    if (rsp === 1'b1) n_rsp <= n_rsp + 1;
    if (srk === 1'b1 && srk_q !== 1'b1) n_srk <= n_srk + 1;
    if (cyc == 40000)
    begin
      n_errors++;
      give_verdict();
    end
  end

  task give_verdict;
    if (n_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // register port: one-cycle strobes, read data sampled in the following cycle
  task reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : reg_write

  task reg_read(input logic [3:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    rd = reg_rdata;
  endtask : reg_read

  // ==========
  // main sequence
  initial
  begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    chk(match, 0);
    reg_read(dsc_pkg::OFF_ADDR);
    chk(rd, 0);
    reg_read(dsc_pkg::OFF_CNT);
    chk(rd, 0);
    // write pass: sector and subsector drawn at random
    sec = 5'($random(seed));
    reg_write(dsc_pkg::OFF_ADDR, {20'h0, 4'($random(seed)), 3'h0, sec});
    reg_write(dsc_pkg::OFF_CTRL, 32'h1);
    @(posedge clock);
    init <= 1'b1;
    @(posedge clock);
    init <= 1'b0;
    bempty <= 1'b1;
    permit <= 1'b0;
    wgo <= 1'b1;
    repeat (3) @(negedge clock);
    chk(dgo, 0);
    repeat (4) @(negedge clock);
    chk({dgo, srk, sld}, 3'h7);
    @(posedge clock);
    wgo <= 1'b0;
    repeat (4) @(negedge clock);
    chk(wsl, 1);
    // the first matching sync comes while the address is locked out
    for (i = 0; i < 9000 && match !== 1'b1; i++) @(negedge clock);
    chk({match, wl}, 2'h2);
    @(posedge clock);
    permit <= 1'b1;
    for (i = 0; i < 9000 && wl !== 1'b1; i++) @(negedge clock);
    chk({wl, match, dsec}, {2'h3, sec});
    chk({ssp, wsy}, 2'h3);
    repeat (3) @(negedge clock);
    chk(wsl, 0);
    b1 = n_wsp;
    b2 = n_srk;
    for (i = 0; i < 400 && wle !== 1'b1; i++) @(negedge clock);
    chk({wle, sld, gate}, 3'h7);
    chk(wte, 1);
    repeat (2) @(negedge clock);
    chk(n_wsp - b1, 15);
    chk(n_srk - b2, 15);
    for (i = 0; i < 30 && late !== 1'b1; i++) @(negedge clock);
    chk(late, 1);
    // let the word stage reach the last word of the subsector
    for (i = 0; i < 2200 && fw !== 1'b1; i++) @(negedge clock);
    reg_read(dsc_pkg::OFF_CNT);
    chk({fw, rd[7:4]}, 5'h1f);
    reg_write(dsc_pkg::OFF_STAT, 32'h80);
    reg_read(dsc_pkg::OFF_STAT);
    chk(rd[dsc_pkg::ST_LATE], 0);
    reg_write(dsc_pkg::OFF_CTRL, 32'h0);
    bempty <= 1'b0;
    repeat (3) @(negedge clock);
    chk(wl, 0);
    // read pass with the buffer left full
    sec = 5'($random(seed));
    reg_write(dsc_pkg::OFF_ADDR, {27'h0, sec});
    reg_write(dsc_pkg::OFF_CTRL, 32'h2);
    @(posedge clock);
    rgo <= 1'b1;
    bfull <= 1'b1;
    repeat (10) @(negedge clock);
    chk(rsl, 1);
    @(posedge clock);
    rgo <= 1'b0;
    reg_read(dsc_pkg::OFF_CNT);
    chk(rd[3:0], 0);
    for (i = 0; i < 9000 && rl !== 1'b1; i++) @(negedge clock);
    chk({rl, dsec}, {1'b1, sec});
    for (i = 0; i < 200 && rsync !== 1'b1; i++) @(negedge clock);
    chk(rsync, 1);
    chk(late, 0);
    b1 = n_rsp;
    b2 = n_srk;
    for (i = 0; i < 400 && bld !== 1'b1; i++) @(negedge clock);
    chk({bld, blc}, 2'h3);
    chk(rte, 1);
    repeat (2) @(negedge clock);
    chk(n_rsp - b1, 16);
    chk(n_srk - b2, 16);
    chk(late, 1);
    @(posedge clock);
    tend <= 1'b1;
    @(posedge clock);
    tend <= 1'b0;
    repeat (3) @(negedge clock);
    chk(rl, 0);
    reg_write(dsc_pkg::OFF_CTRL, 32'h0);
    repeat (3) @(negedge clock);
    chk(rsync, 0);
    give_verdict();
  end
endmodule : test_disc_sector_rw_control
